// file: core/spmg_regs.vh
`ifndef SPMG_REGS_VH
`define SPMG_REGS_VH
// Data-space word addresses
`define SPMG_ADDR_SEL_A 16'h7090
`define SPMG_ADDR_SEL_B 16'h7092
`define SPMG_ADDR_PORT_A 16'h7098
`define SPMG_ADDR_PORT_B 16'h709A
`define SPMG_ADDR_PORT_C 16'h709C
`define SPMG_ADDR_PORT_D 16'h709E
// Reset values
`define SPMG_RST_SEL 16'h0000
`define SPMG_RST_PORT 16'h0000
// Field layout of a port register
`define SPMG_DATA_LSB 0
`define SPMG_DATA_MSB 7
`define SPMG_DIR_LSB 8
`define SPMG_DIR_MSB 15
// Pin map: A and B under select A, C, D0 and D1 under select B
`define SPMG_PIN_COUNT 32
`define SPMG_SEL_B_MSB 9
`define SPMG_DEDICATED_ON 6'h3F
`define SPMG_ALL_PINS 32'hFFFF_FFFF
`define SPMG_MUXED_PINS 32'h03FF_FFFF
// Select-B bits with reversed polarity (1 = GPIO)
`define SPMG_SEL_B_INVERT 16'h0103
`endif

// file: core/spmg_pin_mux.v
// How it works
// - Select bit 1 routes pin to peripheral, 0 routes to GPIO; select B bits 0, 1 and 8 are the reverse.
// - Port data and direction act only while pin selects GPIO.
// - Direction 0 makes the GPIO pin an input, driver off.
// - Direction 1 makes the GPIO pin an output driven from data bit.
// - Writing an output pin's data bit sets the driven level.
// - Reading an input pin's data bit returns the sampled pin level.
// - All mux and port registers are words in data space.
// - Select A at 7090h covers port A and port B pins.
// - Select B at 7092h covers port C and port D pins 0, 1.
// - Port A register at 7098h: data low byte, direction high byte.
// - Port B register at 709Ah, same layout as port A.
// - Port C register at 709Ch, data low byte, direction high byte.
// - Port D at 709Eh; pins 2 to 7 are dedicated GPIO, optional.
`include "spmg_regs.vh"
module spmg_pin_mux #(
  parameter HAS_PORT_D_HIGH = 1
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Data-space register port
  input wire [15:0] i_addr,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  output reg o_rd_hit,
  // Peripheral side, 32 pins (A0..A7, B0..B7, C0..C7, D0..D7)
  input wire [31:0] i_periph_out,
  input wire [31:0] i_periph_oe,
  output reg [31:0] o_periph_in,
  // Pins
  input wire [31:0] i_pin,
  output wire [31:0] o_pin,
  output wire [31:0] o_pin_oe
);
  // Mux select registers
  reg [15:0] sel_a;
  reg [15:0] sel_b;
  // Port data and direction registers
  reg [15:0] port_a;
  reg [15:0] port_b;
  reg [15:0] port_c;
  reg [15:0] port_d;
  // Pin synchroniser stages
  reg [31:0] sync1;
  reg [31:0] sync2;
  reg [31:0] sync3;
  reg [31:0] pin_level;
  // Read path
  reg [15:0] next_rdata;
  reg next_hit;
  // Address decode
  wire hit_sel_a;
  wire hit_sel_b;
  wire hit_port_a;
  wire hit_port_b;
  wire hit_port_c;
  wire hit_port_d;
  // Per-pin views
  wire [15:0] sel_b_gpio;
  wire [31:0] pin_present;
  wire [31:0] gpio_on;
  wire [31:0] gpio_data;
  wire [31:0] gpio_dir;

  // Address decode, one word per register
  assign hit_sel_a = (i_addr == `SPMG_ADDR_SEL_A);
  assign hit_sel_b = (i_addr == `SPMG_ADDR_SEL_B);
  assign hit_port_a = (i_addr == `SPMG_ADDR_PORT_A);
  assign hit_port_b = (i_addr == `SPMG_ADDR_PORT_B);
  assign hit_port_c = (i_addr == `SPMG_ADDR_PORT_C);
  assign hit_port_d = (i_addr == `SPMG_ADDR_PORT_D);

  // Mux select A
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_a <= `SPMG_RST_SEL;
    end else if (i_wr_en && hit_sel_a) begin
      sel_a <= i_wdata;
    end
  end

  // Mux select B
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sel_b <= `SPMG_RST_SEL;
    end else if (i_wr_en && hit_sel_b) begin
      sel_b <= i_wdata;
    end
  end

  // Port A
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_a <= `SPMG_RST_PORT;
    end else if (i_wr_en && hit_port_a) begin
      port_a <= i_wdata;
    end
  end

  // Port B
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_b <= `SPMG_RST_PORT;
    end else if (i_wr_en && hit_port_b) begin
      port_b <= i_wdata;
    end
  end

  // Port C
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_c <= `SPMG_RST_PORT;
    end else if (i_wr_en && hit_port_c) begin
      port_c <= i_wdata;
    end
  end

  // Port D
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      port_d <= `SPMG_RST_PORT;
    end else if (i_wr_en && hit_port_d) begin
      port_d <= i_wdata;
    end
  end

  // Three-stage pin synchroniser, change taken when stages 2 and 3 agree
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= 32'h0000_0000;
      sync2 <= 32'h0000_0000;
      sync3 <= 32'h0000_0000;
      pin_level <= 32'h0000_0000;
    end else begin
      sync1 <= i_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_level <= (sync2 & sync3) | (pin_level & (sync2 | sync3));
    end
  end

  // Effective GPIO selection per pin
  assign sel_b_gpio = sel_b ^ `SPMG_SEL_B_INVERT;
  assign pin_present = (HAS_PORT_D_HIGH != 0) ? `SPMG_ALL_PINS : `SPMG_MUXED_PINS;
  // Dedicated D2..D7 are always GPIO
  assign gpio_on = {`SPMG_DEDICATED_ON, ~sel_b_gpio[`SPMG_SEL_B_MSB:0], ~sel_a};

  // Data bits per port
  assign gpio_data[7:0] = port_a[`SPMG_DATA_MSB:`SPMG_DATA_LSB];
  assign gpio_data[15:8] = port_b[`SPMG_DATA_MSB:`SPMG_DATA_LSB];
  assign gpio_data[23:16] = port_c[`SPMG_DATA_MSB:`SPMG_DATA_LSB];
  assign gpio_data[31:24] = port_d[`SPMG_DATA_MSB:`SPMG_DATA_LSB];

  // Direction bits per port
  assign gpio_dir[7:0] = port_a[`SPMG_DIR_MSB:`SPMG_DIR_LSB];
  assign gpio_dir[15:8] = port_b[`SPMG_DIR_MSB:`SPMG_DIR_LSB];
  assign gpio_dir[23:16] = port_c[`SPMG_DIR_MSB:`SPMG_DIR_LSB];
  assign gpio_dir[31:24] = port_d[`SPMG_DIR_MSB:`SPMG_DIR_LSB];

  // Pin drive; absent pins never drive
  genvar g;
  generate
    for (g = 0; g < `SPMG_PIN_COUNT; g = g + 1) begin : g_pin
      wire gpio_out;
      wire gpio_oe;
      assign gpio_out = gpio_data[g] & pin_present[g];
      assign gpio_oe = gpio_dir[g] & pin_present[g];
      assign o_pin[g] = gpio_on[g] ? gpio_out : i_periph_out[g];
      assign o_pin_oe[g] = gpio_on[g] ? gpio_oe : i_periph_oe[g];
    end
  endgenerate

  // Peripheral inputs see the pin only when routed there
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_periph_in <= 32'h0000_0000;
    end else begin
      o_periph_in <= pin_level & ~gpio_on & pin_present;
    end
  end

  // Read data: input pins show sampled level, output pins the written bit
  wire [31:0] data_view;
  assign data_view = ((gpio_dir & gpio_data) | (~gpio_dir & pin_level)) & pin_present;
  always @* begin
    next_rdata = 16'h0000;
    next_hit = 1'b1;
    case (i_addr)
      `SPMG_ADDR_SEL_A: next_rdata = sel_a;
      `SPMG_ADDR_SEL_B: next_rdata = sel_b;
      `SPMG_ADDR_PORT_A: next_rdata = {port_a[15:8], data_view[7:0]};
      `SPMG_ADDR_PORT_B: next_rdata = {port_b[15:8], data_view[15:8]};
      `SPMG_ADDR_PORT_C: next_rdata = {port_c[15:8], data_view[23:16]};
      `SPMG_ADDR_PORT_D: next_rdata = {port_d[15:8], data_view[31:24]};
      default: next_hit = 1'b0;
    endcase
  end

  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
      o_rd_hit <= 1'b0;
    end else begin
      o_rdata <= i_rd_en ? next_rdata : 16'h0000;
      o_rd_hit <= i_rd_en & next_hit;
    end
  end
endmodule

// file: verification/spmg_board.sv
module spmg_board(input [31:0] o_pin, input [31:0] o_pin_oe, input [31:0] i_drv,
  output [31:0] o_level);
  timeunit 1ns;
  timeprecision 1ps;
  // Board wins wherever the pin driver is off
  assign o_level = (o_pin_oe & o_pin) | (~o_pin_oe & i_drv);
endmodule

// file: verification/spmg_pin_mux_asserts.sv
module spmg_pin_mux_asserts(input i_sys_clk, input i_rst, input [15:0] i_addr,
  input i_wr_en, input i_rd_en, input [15:0] i_wdata, input [15:0] o_rdata, input o_rd_hit,
  input [31:0] i_periph_out, input [31:0] i_periph_oe, input [31:0] o_pin,
  input [31:0] o_pin_oe);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sa;
  always @(posedge i_sys_clk or posedge i_rst)
    if (i_rst) sa <= 16'h0000;
    else if (i_wr_en && i_addr == 16'h7090) sa <= i_wdata;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_PERIPH_A: assert property (sa[0] |-> o_pin[0] == i_periph_out[0]) else $error("mux");
  AST_DIR_A: assert property (i_wr_en && i_addr == 16'h7098 |=>
    sa[0] || o_pin_oe[0] == $past(i_wdata[8])) else $error("dir a");
  AST_LVL_A: assert property (i_wr_en && i_addr == 16'h7098 |=>
    sa[0] || !o_pin_oe[0] || o_pin[0] == $past(i_wdata[0])) else $error("lvl a");
  AST_DIR_B: assert property (i_wr_en && i_addr == 16'h709A |=>
    sa[8] || o_pin_oe[8] == $past(i_wdata[8])) else $error("dir b");
  AST_RD_HIT: assert property (i_rd_en && i_addr == 16'h7090 |=> o_rd_hit) else $error("hit");
  AST_RD_SEL: assert property (i_rd_en && i_addr == 16'h7090 |=> o_rdata == $past(sa))
    else $error("sel rd");
  AST_RD_MISS: assert property (i_rd_en && i_addr == 16'h7094 |=> !o_rd_hit && o_rdata == 0)
    else $error("miss");
  AST_REV: assert property (i_wr_en && i_addr == 16'h7092 && !i_wdata[0] |=>
    o_pin_oe[16] == i_periph_oe[16]) else $error("rev");
  cover property (i_rd_en && i_addr == 16'h709E);
  cover property (sa == 16'hFFFF);
  cover property (i_wr_en && i_addr == 16'h7092);
endmodule
bind spmg_pin_mux spmg_pin_mux_asserts chk_u(.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_rd_hit(o_rd_hit), .i_periph_out(i_periph_out), .i_periph_oe(i_periph_oe), .o_pin(o_pin),
  .o_pin_oe(o_pin_oe));

// file: verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, we = 0, re = 0, hit;
  logic [15:0] a = 0, d = 0, lf = 16'h0047, rd_d, m[6];
  logic [16:0] q[$], qe;
  logic [15:0] av[6] = '{16'h7090, 16'h7092, 16'h7098, 16'h709A, 16'h709C, 16'h709E};
  logic [31:0] po = 0, pe = 0, drv = 32'h5A3C_96E1, pin, op, oe, pi;
  int errors = 0, tests_run = 0;
  spmg_pin_mux dut_u(.i_sys_clk(clk), .i_rst(rst), .i_addr(a), .i_wr_en(we), .i_rd_en(re),
    .i_wdata(d), .o_rdata(rd_d), .o_rd_hit(hit), .i_periph_out(po), .i_periph_oe(pe),
    .o_periph_in(pi), .i_pin(pin), .o_pin(op), .o_pin_oe(oe));
  spmg_board brd_u(.o_pin(op), .o_pin_oe(oe), .i_drv(drv), .o_level(pin));
  function logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task wr(input logic [15:0] ad, input logic [15:0] dv);
    a = ad; d = dv; we = 1;
    @(posedge clk); #1 we = 0;
    @(posedge clk); #1;
  endtask
  task rd(input logic [15:0] ad, input logic [15:0] ex, input logic h);
    a = ad; re = 1; q.push_back({h, ex});
    @(posedge clk); #1 re = 0;
    @(posedge clk); #1;
  endtask
  task end_sim;
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (re) begin
    #0.5 qe = q.pop_front();
    chk(rd_d, qe[15:0]);
    chk({15'h0000, hit}, {15'h0000, qe[16]});
  end
  initial begin
    #5000 errors++;
    end_sim;
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    @(posedge clk); #1;
    m[0] = 16'h0000; m[1] = 16'h0103;
    for (int i = 2; i < 6; i++) begin
      lf = lfsr(lf); m[i] = lf;
    end
    foreach (av[i]) wr(av[i], m[i]);
    foreach (av[i]) rd(av[i], i < 2 ? m[i] : {m[i][15:8],
      (m[i][7:0] & m[i][15:8]) | (drv[8 * (i - 2) +: 8] & ~m[i][15:8])}, 1'b1);
    rd(16'h7094, 16'h0000, 1'b0);
    $display("regs done");
    lf = lfsr(lf); po = {lf, ~lf}; pe = ~po;
    wr(16'h7090, 16'hFFFF);
    chk(op[15:0], po[15:0]);
    chk(oe[15:0], pe[15:0]);
    repeat (6) @(posedge clk);
    #1 chk(pi[15:0], po[15:0] & drv[15:0]);
    chk(pi[31:16], 16'h0000);
    wr(16'h7092, 16'h0000);
    chk({13'h0000, op[24], op[17:16]}, {13'h0000, po[24], po[17:16]});
    chk({13'h0000, oe[24], oe[17:16]}, {13'h0000, pe[24], pe[17:16]});
    chk({10'h000, oe[23:18]}, {10'h000, m[4][15:10]});
    $display("mux done");
    end_sim;
  end
endmodule
